//--- hw/ims_sequencer.sv
`timescale 1ns/100ps
// Contract
// - restart from idle pulls SCL low, then loads 6-bit reload, releases SDA one period.
// - on timeout with SDA high release SCL; when high reload, wait, then SDA low.
// - restart end clears request, keeps SDA low, start flag, interrupt on timeout.
// - restart request ignored while another bus event runs.
// - restart collision if SDA low as SCL rises or SCL falls early.
// - buffer write during any sequence is dropped and sets write collision.
// - low five sequence bits locked until the running sequence completes.
// - buffer write when idle sets buffer full, starts counter, shifts byte out.
// - transmit changes SDA in the same cycle it pulls SCL low, one period low, one period high.
// - after bit eight clear buffer full, release SDA, sample ack into status.
// - after ninth clock set interrupt, stop counter, hold SCL low.
// - receive toggles SCL, shifts SDA, after eight bits loads buffer and flags.
// - reading the buffer after receive clears buffer full.
// - byte arriving while buffer full sets receive overflow.
// - ack sequence drives ack bit, low period, release, high period, low, idle.
// - stop drives SDA low, period, release SCL, period, release SDA, stop flag.
// - one period after stop clears stop request and sets interrupt.
// - released SCL holds counter until SCL reads high, then reloads.
// - in sleep the unit keeps working and wakes on interrupt if enabled.
// - reset or disable aborts transfers and clears start and stop flags.
// - start and stop flags show bus state; interrupt on stop when enabled.
// - sampled SDA compared to driven level; mismatch sets bus collision.
// - baud counter steps twice per instruction cycle and stops at zero.
// - bus collision aborts, releases lines, clears requests, returns to idle.
module ims_sequencer
   import ims_pkg::*;
#(
   parameter int TICK_DIV = 2
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // axi4-lite write
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // two-wire bus
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // system
   input wire logic sleep_i,
   output logic irq_o,
   output logic wake_o
);
   if (TICK_DIV < 1) begin : g_chk
      $error("TICK_DIV must be at least 1");
   end

   localparam int DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

   ims_line_t line_m_reg, line_s_reg, line_p_reg;
   ims_state_t state_reg;
   ims_op_t op_reg;
   ims_stat_t stat_reg;
   logic [IMS_CTRL_W-1:0] ctrl_reg;
   logic [IMS_RELOAD_W-1:0] baud_reload_reg;
   logic [IMS_RELOAD_W-1:0] baud_counter;
   logic [IMS_REQ_W-1:0] seq_reg;
   logic ack_data_reg, ack_status_reg;
   logic [7:0] transfer_buffer, shift_register;
   logic [3:0] bitcnt_reg;
   logic scl_low_reg, sda_low_reg;
   logic [DW-1:0] div_reg;
   logic tick, tmo, col, busy;
   logic [IMS_RELOAD_W-1:0] reload_full, reload_rs;
   // bus slave
   logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
   logic [31:0] awaddr_reg, wdata_reg, rdata_reg;
   logic wstrb0_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic wr_fire, rd_fire, wr_en, rd_buf;
   logic wr_ctrl, wr_seq, wr_baud, wr_buf, wr_stat;

   function automatic logic mapped(input logic [31:0] a);
      return (a == IMS_OFF_CTRL) || (a == IMS_OFF_SEQ) || (a == IMS_OFF_BAUD)
         || (a == IMS_OFF_BUF) || (a == IMS_OFF_STAT);
   endfunction

   // pin synchronisers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         line_m_reg <= '1;
         line_s_reg <= '1;
         line_p_reg <= '1;
      end else begin
         line_m_reg <= '{scl: scl_i, sda: sda_i};
         line_s_reg <= line_m_reg;
         line_p_reg <= line_s_reg;
      end
   end

   // baud tick: two per four-phase instruction cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || div_reg == DW'(TICK_DIV - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end
   assign tick = (div_reg == DW'(TICK_DIV - 1));

   // write channel
   assign s_axi_awready_o = !aw_hold_reg;
   assign s_axi_wready_o = !w_hold_reg;
   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_en = wr_fire && wstrb0_reg && mapped(awaddr_reg);
   assign wr_ctrl = wr_en && awaddr_reg == IMS_OFF_CTRL;
   assign wr_seq = wr_en && awaddr_reg == IMS_OFF_SEQ;
   assign wr_baud = wr_en && awaddr_reg == IMS_OFF_BAUD;
   assign wr_buf = wr_en && awaddr_reg == IMS_OFF_BUF && ctrl_reg[IMS_CTRL_EN];
   assign wr_stat = wr_en && awaddr_reg == IMS_OFF_STAT;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb0_reg <= 1'b0;
         bresp_reg <= IMS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i;
            wstrb0_reg <= s_axi_wstrb_i[0];
         end
         if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(awaddr_reg) ? IMS_RESP_OKAY : IMS_RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;

   // read channel
   assign s_axi_arready_o = !rvalid_reg;
   assign rd_fire = s_axi_arvalid_i && !rvalid_reg;
   assign rd_buf = rd_fire && s_axi_araddr_i == IMS_OFF_BUF;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= IMS_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= mapped(s_axi_araddr_i) ? IMS_RESP_OKAY : IMS_RESP_SLVERR;
         case (s_axi_araddr_i)
            IMS_OFF_CTRL: rdata_reg <= 32'(ctrl_reg);
            IMS_OFF_SEQ: rdata_reg <= 32'({ack_status_reg, ack_data_reg, seq_reg});
            IMS_OFF_BAUD: rdata_reg <= 32'(baud_reload_reg);
            IMS_OFF_BUF: rdata_reg <= 32'(transfer_buffer);
            IMS_OFF_STAT: rdata_reg <= 32'(stat_reg);
            default: rdata_reg <= '0;
         endcase
      end else if (s_axi_rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;

   // software-only settings
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= '0;
         baud_reload_reg <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= wdata_reg[IMS_CTRL_W-1:0];
         end
         if (wr_baud) begin
            baud_reload_reg <= wdata_reg[IMS_RELOAD_W-1:0];
         end
      end
   end

   assign reload_full = baud_reload_reg;
   assign reload_rs = {1'b0, baud_reload_reg[IMS_RS_RELOAD_W-1:0]};
   assign tmo = (baud_counter == '0);
   assign busy = (state_reg != S_IDLE);

   // arbitration and collision watch
   always_comb begin
      col = 1'b0;
      case (state_reg)
         S_RS_SDAHI: col = tmo && !line_s_reg.sda;
         S_REL: col = (op_reg == OP_RS) && line_s_reg.scl && !line_s_reg.sda;
         S_HIGH: begin
            if (op_reg == OP_RS || op_reg == OP_STOP) begin
               col = !line_s_reg.scl && !sda_low_reg;
            end else if (op_reg == OP_ACK || (op_reg == OP_TX && bitcnt_reg != IMS_ACK_SLOT)) begin
               col = !sda_low_reg && !line_s_reg.sda;
            end
         end
         S_SP_SDAREL: col = !line_s_reg.scl;
         default: col = 1'b0;
      endcase
   end

   // sequencer, flags and buffer
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !ctrl_reg[IMS_CTRL_EN]) begin
         state_reg <= S_IDLE;
         op_reg <= OP_TX;
         stat_reg <= '0;
         seq_reg <= '0;
         ack_data_reg <= 1'b0;
         ack_status_reg <= 1'b0;
         transfer_buffer <= IMS_RESET_BYTE;
         shift_register <= IMS_RESET_BYTE;
         bitcnt_reg <= '0;
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         baud_counter <= '0;
      end else begin
         if (tick && !tmo) begin
            baud_counter <= baud_counter - 1'b1;
         end
         // software clears go first so hardware sets win
         if (wr_stat) begin
            stat_reg <= stat_reg & ~ims_stat_t'(wdata_reg[$bits(ims_stat_t)-1:0]);
         end
         if (wr_seq) begin
            ack_data_reg <= wdata_reg[IMS_SEQ_ACK_DATA_BIT];
            if (!busy) begin
               seq_reg <= wdata_reg[IMS_REQ_W-1:0];
            end
         end
         if (rd_buf && op_reg == OP_RX) begin
            stat_reg.buf_full <= 1'b0;
         end
         if (wr_buf && busy) begin
            stat_reg.wr_col <= 1'b1;
         end
         // bus condition monitor
         if (line_s_reg.scl && line_p_reg.scl && line_p_reg.sda && !line_s_reg.sda) begin
            stat_reg.start_det <= 1'b1;
            stat_reg.stop_det <= 1'b0;
         end
         if (line_s_reg.scl && line_p_reg.scl && !line_p_reg.sda && line_s_reg.sda) begin
            stat_reg.stop_det <= 1'b1;
            stat_reg.start_det <= 1'b0;
            // foreign stop frees the bus; our own stop flags it one period later
            if (!(busy && op_reg == OP_STOP)) begin
               stat_reg.irq <= 1'b1;
            end
         end
         if (col) begin
            state_reg <= S_IDLE;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            seq_reg <= '0;
            stat_reg.bus_col <= 1'b1;
            if (op_reg == OP_TX) begin
               stat_reg.buf_full <= 1'b0;
            end
         end else begin
            case (state_reg)
               S_IDLE: begin
                  if (wr_buf) begin
                     transfer_buffer <= wdata_reg[7:0];
                     shift_register <= wdata_reg[7:0];
                     stat_reg.buf_full <= 1'b1;
                     bitcnt_reg <= '0;
                     op_reg <= OP_TX;
                     scl_low_reg <= 1'b1;
                     sda_low_reg <= !wdata_reg[7];
                     baud_counter <= reload_full;
                     state_reg <= S_LOW;
                  end else if (seq_reg[IMS_SEQ_RS]) begin
                     scl_low_reg <= 1'b1;
                     op_reg <= OP_RS;
                     state_reg <= S_RS_SCLLO;
                  end else if (seq_reg[IMS_SEQ_STOP]) begin
                     scl_low_reg <= 1'b1;
                     sda_low_reg <= 1'b1;
                     op_reg <= OP_STOP;
                     state_reg <= S_SP_SDALO;
                  end else if (seq_reg[IMS_SEQ_RX]) begin
                     scl_low_reg <= 1'b1;
                     sda_low_reg <= 1'b0;
                     bitcnt_reg <= '0;
                     op_reg <= OP_RX;
                     baud_counter <= reload_full;
                     state_reg <= S_LOW;
                  end else if (seq_reg[IMS_SEQ_ACK]) begin
                     scl_low_reg <= 1'b1;
                     sda_low_reg <= !ack_data_reg;
                     op_reg <= OP_ACK;
                     baud_counter <= reload_full;
                     state_reg <= S_LOW;
                  end
               end
               S_RS_SCLLO: begin
                  if (!line_s_reg.scl) begin
                     baud_counter <= reload_rs;
                     sda_low_reg <= 1'b0;
                     state_reg <= S_RS_SDAHI;
                  end
               end
               S_RS_SDAHI: begin
                  if (tmo) begin
                     scl_low_reg <= 1'b0;
                     state_reg <= S_REL;
                  end
               end
               S_LOW: begin
                  if (tmo) begin
                     scl_low_reg <= 1'b0;
                     state_reg <= S_REL;
                  end
               end
               S_REL: begin
                  if (line_s_reg.scl) begin
                     baud_counter <= reload_full;
                     state_reg <= S_HIGH;
                  end
               end
               S_HIGH: begin
                  if (tmo) begin
                     case (op_reg)
                        OP_RS: begin
                           sda_low_reg <= 1'b1;
                           baud_counter <= reload_full;
                           state_reg <= S_RS_SDALO;
                        end
                        OP_STOP: begin
                           sda_low_reg <= 1'b0;
                           state_reg <= S_SP_SDAREL;
                        end
                        OP_ACK: begin
                           scl_low_reg <= 1'b1;
                           seq_reg[IMS_SEQ_ACK] <= 1'b0;
                           stat_reg.irq <= 1'b1;
                           state_reg <= S_IDLE;
                        end
                        OP_TX: begin
                           scl_low_reg <= 1'b1;
                           if (bitcnt_reg == IMS_ACK_SLOT) begin
                              ack_status_reg <= line_s_reg.sda;
                              stat_reg.irq <= 1'b1;
                              state_reg <= S_IDLE;
                           end else begin
                              if (bitcnt_reg == IMS_LAST_DATA) begin
                                 stat_reg.buf_full <= 1'b0;
                              end
                              shift_register <= {shift_register[6:0], 1'b1};
                              sda_low_reg <= !shift_register[6];
                              bitcnt_reg <= bitcnt_reg + 1'b1;
                              baud_counter <= reload_full;
                              state_reg <= S_LOW;
                           end
                        end
                        OP_RX: begin
                           scl_low_reg <= 1'b1;
                           shift_register <= {shift_register[6:0], line_s_reg.sda};
                           if (bitcnt_reg == IMS_LAST_DATA) begin
                              transfer_buffer <= {shift_register[6:0], line_s_reg.sda};
                              stat_reg.rx_ovf <= stat_reg.rx_ovf | stat_reg.buf_full;
                              stat_reg.buf_full <= 1'b1;
                              stat_reg.irq <= 1'b1;
                              seq_reg[IMS_SEQ_RX] <= 1'b0;
                              state_reg <= S_IDLE;
                           end else begin
                              bitcnt_reg <= bitcnt_reg + 1'b1;
                              baud_counter <= reload_full;
                              state_reg <= S_LOW;
                           end
                        end
                        default: state_reg <= S_IDLE;
                     endcase
                  end
               end
               S_RS_SDALO: begin
                  if (tmo) begin
                     seq_reg[IMS_SEQ_RS] <= 1'b0;
                     stat_reg.irq <= 1'b1;
                     scl_low_reg <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end
               S_SP_SDALO: begin
                  if (!line_s_reg.sda) begin
                     baud_counter <= reload_full;
                     state_reg <= S_LOW;
                  end
               end
               S_SP_SDAREL: begin
                  if (line_s_reg.sda) begin
                     baud_counter <= reload_full;
                     state_reg <= S_SP_END;
                  end
               end
               S_SP_END: begin
                  if (tmo) begin
                     seq_reg[IMS_SEQ_STOP] <= 1'b0;
                     stat_reg.irq <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end
               default: state_reg <= S_IDLE;
            endcase
         end
      end
   end

   // open-drain pins: only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_low_reg;
   assign sda_oe_o = sda_low_reg;

   assign irq_o = stat_reg.irq && ctrl_reg[IMS_CTRL_IE];
   assign wake_o = irq_o && sleep_i;
endmodule

//--- hw/ims_pkg.sv
package ims_pkg;
   // register byte offsets
   localparam logic [31:0] IMS_OFF_CTRL = 32'h0000_0000;
   localparam logic [31:0] IMS_OFF_SEQ = 32'h0000_0004;
   localparam logic [31:0] IMS_OFF_BAUD = 32'h0000_0008;
   localparam logic [31:0] IMS_OFF_BUF = 32'h0000_000C;
   localparam logic [31:0] IMS_OFF_STAT = 32'h0000_0010;
   // control register bits
   localparam int IMS_CTRL_EN = 0;
   localparam int IMS_CTRL_IE = 1;
   localparam int IMS_CTRL_W = 2;
   // sequence_control_reg bits
   localparam int IMS_SEQ_RS = 1;
   localparam int IMS_SEQ_STOP = 2;
   localparam int IMS_SEQ_RX = 3;
   localparam int IMS_SEQ_ACK = 4;
   localparam int IMS_SEQ_ACK_DATA_BIT = 5;
   localparam int IMS_SEQ_ACKST = 6;
   localparam int IMS_REQ_W = 5;
   // baud reload field widths
   localparam int IMS_RELOAD_W = 7;
   localparam int IMS_RS_RELOAD_W = 6;
   // byte framing, bus response codes and reset byte
   localparam logic [3:0] IMS_LAST_DATA = 4'h7;
   localparam logic [3:0] IMS_ACK_SLOT = 4'h8;
   localparam logic [1:0] IMS_RESP_OKAY = 2'h0;
   localparam logic [1:0] IMS_RESP_SLVERR = 2'h2;
   localparam logic [7:0] IMS_RESET_BYTE = 8'h00;

   typedef struct packed {
      logic scl;
      logic sda;
   } ims_line_t;

   // status register layout, bit 0 is buf_full
   typedef struct packed {
      logic irq;
      logic bus_col;
      logic rx_ovf;
      logic wr_col;
      logic stop_det;
      logic start_det;
      logic buf_full;
   } ims_stat_t;

   typedef enum logic [9:0] {
      S_IDLE = 10'b00_0000_0001,
      S_RS_SCLLO = 10'b00_0000_0010,
      S_RS_SDAHI = 10'b00_0000_0100,
      S_LOW = 10'b00_0000_1000,
      S_REL = 10'b00_0001_0000,
      S_HIGH = 10'b00_0010_0000,
      S_RS_SDALO = 10'b00_0100_0000,
      S_SP_SDALO = 10'b00_1000_0000,
      S_SP_SDAREL = 10'b01_0000_0000,
      S_SP_END = 10'b10_0000_0000
   } ims_state_t;

   typedef enum logic [2:0] {
      OP_RS = 3'h0,
      OP_TX = 3'h1,
      OP_RX = 3'h2,
      OP_ACK = 3'h3,
      OP_STOP = 3'h4
   } ims_op_t;
endpackage

//--- verification/ims_sequencer_assertions.sv
`timescale 1ns/100ps
module ims_sequencer_assertions #(
   parameter int TICK_DIV = 2
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // bus lines
   input wire logic scl_i,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o,
   // system
   input wire logic sleep_i,
   input wire logic irq_o,
   input wire logic wake_o,
   // register bus
   input wire logic s_axi_arready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_rst_idle; disable iff (1'b0) sys_rst_i |=> !scl_oe_o && !sda_oe_o && !irq_o; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("active after reset");
   property p_wake; wake_o == (irq_o && sleep_i); endproperty
   a_wake: assert property (p_wake) else $error("wake mismatch");
   property p_low_hold; $rose(scl_oe_o) |-> scl_oe_o [*2]; endproperty
   a_low_hold: assert property (p_low_hold) else $error("scl low too short");
   property p_stretch; $fell(scl_oe_o) ##1 !scl_i [*3] |-> !scl_oe_o; endproperty
   a_stretch: assert property (p_stretch) else $error("scl pulled while stretched");
   property p_irq_hold; $rose(irq_o) |-> ##2 $stable(scl_oe_o) [*2]; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("scl moved after irq");
   property p_bfall; $fell(s_axi_bvalid_o) |-> $past(s_axi_bready_i); endproperty
   a_bfall: assert property (p_bfall) else $error("bvalid dropped early");
   property p_rfall; $fell(s_axi_rvalid_o) |-> $past(s_axi_rready_i); endproperty
   a_rfall: assert property (p_rfall) else $error("rvalid dropped early");
   property p_arready; s_axi_arready_o == !s_axi_rvalid_o; endproperty
   a_arready: assert property (p_arready) else $error("arready mismatch");
endmodule
bind ims_sequencer ims_sequencer_assertions #(.TICK_DIV(TICK_DIV)) u_chk (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .scl_oe_o(scl_oe_o),
   .sda_oe_o(sda_oe_o), .sleep_i(sleep_i), .irq_o(irq_o), .wake_o(wake_o),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i)
);

//--- verification/ims_slave_model.sv
`timescale 1ns/100ps
module ims_slave_model (
   // clock and wire levels
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   // behaviour
   input wire logic rx_mode,
   input wire logic [7:0] tx_byte,
   input wire logic [7:0] stretch,
   // pulls and captured byte
   output logic scl_pull,
   output logic sda_pull,
   output logic [7:0] rx_byte
);
   logic ps = 1'b1;
   logic pd = 1'b1;
   logic [3:0] cnt = 4'h0;
   logic [7:0] hold = 8'h00;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      rx_byte = 8'h00;
   end
   always @(posedge clk) begin
      ps <= scl;
      pd <= sda;
      // stretch each low phase of scl
      if (!scl && ps && stretch != 8'h00) begin
         scl_pull <= 1'b1;
         hold <= stretch;
      end else if (hold != 8'h00) hold <= hold - 8'h01;
      else scl_pull <= 1'b0;
      // start or stop restarts bit count
      if (scl && ps && pd != sda) cnt <= 4'h0;
      else if (scl && !ps) begin
         cnt <= cnt + 4'h1;
         if (cnt < 4'h8) rx_byte <= {rx_byte[6:0], sda};
      end else if (!scl && ps) begin
         if (cnt == 4'h8) sda_pull <= !rx_mode;
         else if (cnt == 4'h9) sda_pull <= 1'b0;
         else if (rx_mode && cnt < 4'h8) sda_pull <= !tx_byte[3'h7 - cnt[2:0]];
      end
   end
endmodule

//--- verification/test_ims_sequencer.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_ims_sequencer;
   import ims_pkg::*;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [31:0] awaddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic sleep = 1'b0;
   logic rx_mode = 1'b0;
   logic [7:0] stretch = 8'h00;
   wire logic awready, wready, bvalid, arready, rvalid, irq, wake;
   wire logic scl_oe, sda_oe, m_scl, m_sda, scl_lv, sda_lv;
   wire logic [1:0] rresp, bresp;
   wire logic [31:0] rdata;
   wire logic [7:0] rx_byte;
   wire logic scl_w = !(scl_oe | m_scl);
   wire logic sda_w = !(sda_oe | m_sda);
   int num_errors = 0;
   int n_compared = 0;
   always #5 mclk_i = ~mclk_i;
   ims_sequencer #(.TICK_DIV(1)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'h1),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(1'h1), .scl_i(scl_w), .scl_o(scl_lv), .scl_oe_o(scl_oe), .sda_i(sda_w),
      .sda_o(sda_lv), .sda_oe_o(sda_oe), .sleep_i(sleep), .irq_o(irq), .wake_o(wake)
   );
   ims_slave_model u_slave (
      .clk(mclk_i), .scl(scl_w), .sda(sda_w), .rx_mode(rx_mode), .tx_byte(8'h5A),
      .stretch(stretch), .scl_pull(m_scl), .sda_pull(m_sda), .rx_byte(rx_byte)
   );
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge mclk_i);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge mclk_i); while (!bvalid);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge mclk_i); while (!arready);
      arvalid <= 1'b0;
      do @(posedge mclk_i); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
   task automatic chk_rd(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(n, e, d)
   endtask
   task automatic wait_irq;
      int i;
      i = 0;
      while (irq !== 1'b1 && i < 4000) begin
         @(posedge mclk_i);
         i++;
      end
      `CHK("irq", 1'b1, irq)
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (8) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      chk_rd("stat", IMS_OFF_STAT, 32'h0);
      rd(32'h20, d, r);
      `CHK("unmapped", IMS_RESP_SLVERR, r)
      wr(32'h20, 32'h0);
      `CHK("wr unmapped", IMS_RESP_SLVERR, bresp)
      `CHK("pin level", 2'b00, {scl_lv, sda_lv})
      wr(IMS_OFF_BAUD, 32'h2);
      wr(IMS_OFF_CTRL, 32'h3);
      $display("registers done");
      stretch <= 8'h0C;
      wr(IMS_OFF_BUF, 32'hA5);
      chk_rd("stat bf", IMS_OFF_STAT, 32'h1);
      wr(IMS_OFF_BUF, 32'h3C);
      wait_irq;
      `CHK("wire byte", 8'hA5, rx_byte)
      chk_rd("buf kept", IMS_OFF_BUF, 32'hA5);
      chk_rd("ack_status_flag", IMS_OFF_SEQ, 32'h0);
      chk_rd("stat tx", IMS_OFF_STAT, 32'h48);
      wr(IMS_OFF_STAT, 32'h7F);
      chk_rd("stat clr", IMS_OFF_STAT, 32'h0);
      $display("transmit done");
      stretch <= 8'h00;
      rx_mode <= 1'b1;
      wr(IMS_OFF_SEQ, 32'h2);
      wr(IMS_OFF_SEQ, 32'hA);
      chk_rd("seq busy", IMS_OFF_SEQ, 32'h2);
      wait_irq;
      chk_rd("seq rs", IMS_OFF_SEQ, 32'h0);
      chk_rd("stat rs", IMS_OFF_STAT, 32'h42);
      wr(IMS_OFF_STAT, 32'h7F);
      $display("restart done");
      sleep <= 1'b1;
      wr(IMS_OFF_SEQ, 32'h8);
      wait_irq;
      `CHK("wake", 1'b1, wake)
      chk_rd("stat rx", IMS_OFF_STAT, 32'h41);
      chk_rd("rx byte", IMS_OFF_BUF, 32'h5A);
      chk_rd("stat rd", IMS_OFF_STAT, 32'h40);
      wr(IMS_OFF_STAT, 32'h7F);
      sleep <= 1'b0;
      $display("receive done");
      wr(IMS_OFF_SEQ, 32'h30);
      wait_irq;
      chk_rd("seq ack", IMS_OFF_SEQ, 32'h20);
      wr(IMS_OFF_STAT, 32'h7F);
      $display("ack done");
      wr(IMS_OFF_SEQ, 32'h4);
      wait_irq;
      chk_rd("seq stop", IMS_OFF_SEQ, 32'h0);
      chk_rd("stat stop", IMS_OFF_STAT, 32'h44);
      $display("stop done");
      wr(IMS_OFF_STAT, 32'h7F);
      wr(IMS_OFF_SEQ, 32'h8);
      wait_irq;
      wr(IMS_OFF_STAT, 32'h40);
      wr(IMS_OFF_SEQ, 32'h8);
      wait_irq;
      chk_rd("stat ovf", IMS_OFF_STAT, 32'h51);
      $display("overflow done");
      test_done;
   end
   initial begin
      repeat (40000) @(posedge mclk_i);
      num_errors++;
      test_done;
   end
endmodule
